// ===== clk_cfg.svh
// constants for the display clock configuration block
`ifndef CLK_CFG_SVH
`define CLK_CFG_SVH

// register indices; 0x1E is not a multiple of four, so the byte address is four times the index
`define IDX_MEM_CLK      8'h10
`define IDX_PANEL_CLK    8'h14
`define IDX_MONTV_CLK    8'h18
`define IDX_MEDIA_CLK    8'h1C
`define IDX_WAIT_SEL     8'h1E

// field positions
`define MEM_SRC_BIT      0
`define MEM_DIV_BIT      4
`define DBL_BIT          7
`define DIV_LSB          4
`define SRC_LSB          0

// writable bit masks per register
`define MEM_CLK_MASK     8'h11
`define PIX_CLK_MASK     8'h33
`define MONTV_CLK_MASK   8'hB3
`define WAIT_SEL_MASK    8'h03

// reset values
`define CLK_CFG_RESET    8'h00
`define STRAP_RESET      16'h0000
`define STRAP_BUSDIV_BIT 12

`endif

// ===== clk_divider.sv
// one source mux plus divide by 1 to 4, producing a clock enable pulse
`timescale 1ns/1ns
module clk_divider (
    input  wire logic               i_clk,
    input  wire logic               i_reset_n,
    input  wire logic [3:0]         i_sources,
    input  wire clk_pkg::src_sel_type i_src_sel,
    input  wire clk_pkg::div_sel_type i_div_sel,
    input  wire logic               i_double,
    output logic                    o_tick
);
    import clk_pkg::*;

    // **********************************************
    // source selection and edge detection
    // **********************************************
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic       src_reg;
    logic       src_now;
    logic       src_rise;
    logic       src_edge;
    logic       wrap;

    assign src_now  = i_sources[i_src_sel];
    assign src_rise = src_now & ~src_reg;
    // doubling counts both edges of the source
    assign src_edge = i_double ? (src_now ^ src_reg) : src_rise;
    // counter wraps at the divide code: code 0 = 1:1, code 3 = 4:1
    assign wrap     = src_edge & (cnt_reg == i_div_sel);
    assign cnt_next = wrap ? 2'h0 : (src_edge ? cnt_reg + 2'h1 : cnt_reg);

    // edge tracker and divide counter
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            src_reg <= 1'b0;
            cnt_reg <= 2'h0;
            o_tick  <= 1'b0;
        end else begin
            src_reg <= src_now;
            cnt_reg <= cnt_next;
            o_tick  <= wrap;
        end
    end
endmodule : clk_divider

// ===== clk_pkg.sv
// types for the display clock configuration block
package clk_pkg;
    typedef logic [1:0] src_sel_type;
    typedef logic [1:0] div_sel_type;
    typedef logic [1:0] wait_sel_type;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_GRANT = 3'b100
    } hand_state_type;
endpackage : clk_pkg

// ===== clock_config.sv
// top of the display clock configuration block with its APB register file
// What this block does
// - memory clock divide bit 4 set halves the selected memory clock source
// - memory source bit 0: one picks host bus clock, zero picks primary input
// - panel pixel divide bits 5-4 give ratios one to four
// - panel source bits 1-0: primary, host bus, secondary, memory clock
// - memory clock as a source means the selected memory clock, halved when divide bit 4 is set
// - monitor/TV double enable bit 7 multiplies its pixel clock by two
// - monitor/TV divide bits 5-4 give ratios one to four
// - monitor/TV source bits 1-0: primary, host bus, secondary, memory clock
// - media port divide bits 5-4 give ratios one to four
// - media port source bits 1-0: primary, host bus, secondary, memory clock
// - internal bus clock is host bus clock or half of it per strap 12
// - strap pins are captured as reset is released and held afterwards
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "clk_cfg.svh"
module clock_config (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET_N,
    // apb slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // clock levels sampled as ordinary inputs
    input  wire logic        I_PRIMARY_CLOCK_INPUT,
    input  wire logic        I_SECONDARY_CLOCK_INPUT,
    input  wire logic        I_HOST_BUS_CLOCK,
    input  wire logic [15:0] I_CONFIG_STRAP_PINS,
    // host request toward the memory controller
    input  wire logic        I_MEM_REQ,
    output logic             O_MEM_GRANT,
    // derived clock enables
    output logic             O_MEMORY_CLOCK,
    output logic             O_PANEL_PIXEL_CLOCK,
    output logic             O_MONITOR_TV_PIXEL_CLOCK,
    output logic             O_MEDIA_PORT_CLOCK,
    output logic             O_INTERNAL_BUS_CLOCK,
    output logic [15:0]      O_CONFIG_STRAP_STATUS
);
    import clk_pkg::*;

    // **********************************************
    // register file
    // **********************************************
    logic [7:0] mem_clk_reg;
    logic [7:0] panel_clk_reg;
    logic [7:0] montv_clk_reg;
    logic [7:0] media_clk_reg;
    logic [7:0] wait_sel_reg;

    // byte address is four times the printed index
    logic       hit_mem;
    logic       hit_panel;
    logic       hit_montv;
    logic       hit_media;
    logic       hit_wait;
    logic       hit_any;
    logic       acc;
    logic       wr;
    logic [7:0] wbyte;
    logic [7:0] rd_mux;

    // decode against index times four; PADDR is the byte address
    logic [9:0] a_mem;
    logic [9:0] a_panel;
    logic [9:0] a_montv;
    logic [9:0] a_media;
    logic [9:0] a_wait;
    assign a_mem     = {`IDX_MEM_CLK, 2'b00};
    assign a_panel   = {`IDX_PANEL_CLK, 2'b00};
    assign a_montv   = {`IDX_MONTV_CLK, 2'b00};
    assign a_media   = {`IDX_MEDIA_CLK, 2'b00};
    assign a_wait    = {`IDX_WAIT_SEL, 2'b00};
    logic [9:0] baddr;
    assign baddr     = {2'b00, I_PADDR};
    assign hit_mem   = (baddr == a_mem);
    assign hit_panel = (baddr == a_panel);
    assign hit_montv = (baddr == a_montv);
    assign hit_media = (baddr == a_media);
    assign hit_wait  = (baddr == a_wait);
    assign hit_any   = hit_mem | hit_panel | hit_montv | hit_media | hit_wait;
    assign acc       = I_PSEL & I_PENABLE;
    assign wr        = acc & I_PWRITE & hit_any;
    assign wbyte     = I_PWDATA[7:0];

    // read mux; unused bits are already zero in storage
    assign rd_mux = hit_mem   ? mem_clk_reg   :
                    hit_panel ? panel_clk_reg :
                    hit_montv ? montv_clk_reg :
                    hit_media ? media_clk_reg :
                    hit_wait  ? wait_sel_reg  : 8'h00;

    // writes keep only the implemented bits
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            mem_clk_reg   <= `CLK_CFG_RESET;
            panel_clk_reg <= `CLK_CFG_RESET;
            montv_clk_reg <= `CLK_CFG_RESET;
            media_clk_reg <= `CLK_CFG_RESET;
            wait_sel_reg  <= `CLK_CFG_RESET;
        end else begin
            if (wr & hit_mem)   mem_clk_reg   <= wbyte & `MEM_CLK_MASK;
            if (wr & hit_panel) panel_clk_reg <= wbyte & `PIX_CLK_MASK;
            if (wr & hit_montv) montv_clk_reg <= wbyte & `MONTV_CLK_MASK;
            if (wr & hit_media) media_clk_reg <= wbyte & `PIX_CLK_MASK;
            if (wr & hit_wait)  wait_sel_reg  <= wbyte & `WAIT_SEL_MASK;
        end
    end

    // apb answer: zero wait states, unmapped addresses give an error
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PRDATA  <= 32'h0000_0000;
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= I_PSEL & ~I_PENABLE;
            O_PSLVERR <= I_PSEL & ~I_PENABLE & ~hit_any;
            O_PRDATA  <= (I_PSEL & ~I_PENABLE & ~I_PWRITE) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // **********************************************
    // strap capture
    // **********************************************
    // captured on the first clock after reset release; a reset flop may not load a port
    logic        strap_done_reg;
    logic [15:0] strap_reg;
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            strap_done_reg <= 1'b0;
            strap_reg      <= `STRAP_RESET;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_reg      <= I_CONFIG_STRAP_PINS;
        end
    end

    // **********************************************
    // memory clock
    // **********************************************
    logic mem_src;
    logic mem_src_reg;
    logic mem_half_reg;
    logic mem_rise;
    logic mem_tick;
    assign mem_src  = mem_clk_reg[`MEM_SRC_BIT] ? I_HOST_BUS_CLOCK : I_PRIMARY_CLOCK_INPUT;
    assign mem_rise = mem_src & ~mem_src_reg;
    // the halving toggles once per source rising edge
    assign mem_tick = mem_rise & (~mem_clk_reg[`MEM_DIV_BIT] | mem_half_reg);

    // memory clock edge tracker and half-rate phase
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            mem_src_reg    <= 1'b0;
            mem_half_reg   <= 1'b0;
            O_MEMORY_CLOCK <= 1'b0;
        end else begin
            mem_src_reg    <= mem_src;
            mem_half_reg   <= mem_rise ? ~mem_half_reg : mem_half_reg;
            O_MEMORY_CLOCK <= mem_tick;
        end
    end

    // level form of the processed memory clock for the pixel muxes; it must rise once per
    // memory tick, so full rate follows the source and halved rate toggles per source rise
    logic mem_level_reg;
    logic mem_level_next;
    assign mem_level_next = mem_clk_reg[`MEM_DIV_BIT] ? (mem_level_reg ^ mem_rise) : mem_src;
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            mem_level_reg <= 1'b0;
        end else begin
            mem_level_reg <= mem_level_next;
        end
    end

    // **********************************************
    // pixel and media clocks
    // **********************************************
    // memory clock entry is the processed one, not a raw input
    logic [3:0] srcs;
    assign srcs = {mem_level_reg, I_SECONDARY_CLOCK_INPUT, I_HOST_BUS_CLOCK, I_PRIMARY_CLOCK_INPUT};

    logic [7:0] cfg   [3];
    logic [2:0] ticks;
    assign cfg[0] = panel_clk_reg;
    assign cfg[1] = montv_clk_reg;
    assign cfg[2] = media_clk_reg;

    // one divider per derived clock; only monitor/TV may double
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_div
            clk_divider u_div (
                .i_clk     (I_CLK),
                .i_reset_n (I_RESET_N),
                .i_sources (srcs),
                .i_src_sel (cfg[g][`SRC_LSB +: 2]),
                .i_div_sel (cfg[g][`DIV_LSB +: 2]),
                .i_double  ((g == 1) ? cfg[g][`DBL_BIT] : 1'b0),
                .o_tick    (ticks[g])
            );
        end
    endgenerate

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PANEL_PIXEL_CLOCK      <= 1'b0;
            O_MONITOR_TV_PIXEL_CLOCK <= 1'b0;
            O_MEDIA_PORT_CLOCK       <= 1'b0;
        end else begin
            O_PANEL_PIXEL_CLOCK      <= ticks[0];
            O_MONITOR_TV_PIXEL_CLOCK <= ticks[1];
            O_MEDIA_PORT_CLOCK       <= ticks[2];
        end
    end

    // **********************************************
    // internal bus clock
    // **********************************************
    logic hb_reg;
    logic hb_half_reg;
    logic hb_rise;
    logic bus_tick;
    assign hb_rise  = I_HOST_BUS_CLOCK & ~hb_reg;
    assign bus_tick = hb_rise & (~strap_reg[`STRAP_BUSDIV_BIT] | hb_half_reg);
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            hb_reg               <= 1'b0;
            hb_half_reg          <= 1'b0;
            O_INTERNAL_BUS_CLOCK <= 1'b0;
            O_CONFIG_STRAP_STATUS <= `STRAP_RESET;
        end else begin
            hb_reg               <= I_HOST_BUS_CLOCK;
            hb_half_reg          <= hb_rise ? ~hb_half_reg : hb_half_reg;
            O_INTERNAL_BUS_CLOCK <= bus_tick;
            O_CONFIG_STRAP_STATUS <= strap_reg;
        end
    end

    // **********************************************
    // host to memory handshake
    // **********************************************
    // wait count in memory clock ticks: code 0 none, 1 one, 2 two; 3 treated as two
    hand_state_type st_reg;
    hand_state_type st_next;
    logic [1:0]     wcnt_reg;
    logic [1:0]     wneed;
    assign wneed = (wait_sel_reg[1:0] == 2'h3) ? 2'h2 : wait_sel_reg[1:0];

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            ST_IDLE:  if (I_MEM_REQ) st_next = (wneed == 2'h0) ? ST_GRANT : ST_WAIT;
            ST_WAIT:  if (mem_tick && (wcnt_reg + 2'h1 >= wneed)) st_next = ST_GRANT;
            ST_GRANT: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_reg      <= ST_IDLE;
            wcnt_reg    <= 2'h0;
            O_MEM_GRANT <= 1'b0;
        end else begin
            st_reg      <= st_next;
            wcnt_reg    <= (st_reg == ST_WAIT) ? (mem_tick ? wcnt_reg + 2'h1 : wcnt_reg) : 2'h0;
            O_MEM_GRANT <= (st_next == ST_GRANT);
        end
    end
endmodule : clock_config

// ===== clock_config_monitor.sv
// assertion checker for the display clock configuration block
`timescale 1ns/1ns
module clock_config_monitor (
    input wire logic        I_CLK,
    input wire logic        I_RESET_N,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    input wire logic [15:0] I_CONFIG_STRAP_PINS,
    input wire logic        I_MEM_REQ,
    input wire logic        O_MEM_GRANT,
    input wire logic        O_MEMORY_CLOCK,
    input wire logic [15:0] O_CONFIG_STRAP_STATUS
);
    import clk_pkg::*;
    wait_sel_type wait_reg;
    logic [1:0]   rel_reg;
    logic [15:0]  cap_reg;
    // writable bits per address; zero means unmapped
    wire logic [7:0] mask_w = (I_PADDR == 8'h40) ? 8'h11 : (I_PADDR == 8'h60) ? 8'hB3 :
                              (I_PADDR == 8'h78) ? 8'h03 : (I_PADDR == 8'h50 || I_PADDR == 8'h70) ? 8'h33 : 8'h00;
    // shadow wait code and strap capture, since the checker cannot see the body
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wait_reg <= 2'h0;
            rel_reg  <= 2'h0;
            cap_reg  <= 16'h0000;
        end else begin
            if (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PADDR == 8'h78)
                wait_reg <= I_PWDATA[1:0];
            if (rel_reg != 2'h3)
                rel_reg <= rel_reg + 2'h1;
            if (rel_reg == 2'h0)
                cap_reg <= I_CONFIG_STRAP_PINS;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence s_setup; I_PSEL && !I_PENABLE; endsequence
    sequence s_req; $rose(I_MEM_REQ); endsequence
    property p_ready; s_setup |=> O_PREADY; endproperty
    property p_mask; O_PREADY && !I_PWRITE |-> (O_PRDATA & ~{24'h0, mask_w}) == 32'h0; endproperty
    property p_err; O_PREADY |-> O_PSLVERR == (mask_w == 8'h00); endproperty
    property p_strap; rel_reg == 2'h3 |-> O_CONFIG_STRAP_STATUS == cap_reg; endproperty
    property p_grant0; s_req ##0 (wait_reg == 2'h0) |=> O_MEM_GRANT; endproperty
    property p_grantw; s_req ##0 (wait_reg != 2'h0) |=> !O_MEM_GRANT; endproperty
    property p_bound; s_req |-> ##[1:80] O_MEM_GRANT; endproperty
    property p_pulse; O_MEM_GRANT |=> !O_MEM_GRANT; endproperty
    property p_mem; O_MEMORY_CLOCK |=> !O_MEMORY_CLOCK; endproperty
    a_ready:  assert property (p_ready) else $error("no ready in access cycle");
    a_mask:   assert property (p_mask) else $error("unused read bits not zero");
    a_err:    assert property (p_err) else $error("error flag wrong for address");
    a_strap:  assert property (p_strap) else $error("strap status not captured value");
    a_grant0: assert property (p_grant0) else $error("grant late with zero wait code");
    a_grantw: assert property (p_grantw) else $error("grant early with wait code");
    a_bound:  assert property (p_bound) else $error("grant never came");
    a_pulse:  assert property (p_pulse) else $error("grant longer than one cycle");
    a_mem:    assert property (p_mem) else $error("memory clock pulse too long");
endmodule : clock_config_monitor

bind clock_config clock_config_monitor mon_u (.I_CLK, .I_RESET_N, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
    .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_CONFIG_STRAP_PINS, .I_MEM_REQ, .O_MEM_GRANT,
    .O_MEMORY_CLOCK, .O_CONFIG_STRAP_STATUS);

// ===== clock_config_tb.sv
// self-checking testbench for the display clock configuration block
`timescale 1ns/1ns
module clock_config_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err;
    logic        pri = 1'b0, sec = 1'b0, hbc = 1'b0, req = 1'b0;
    logic [15:0] straps = 16'h1234, status;
    logic        grant, mclk, pclk, tclk, dclk, bclk;
    logic [7:0]  ra [5] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h78};
    logic [7:0]  rm [5] = '{8'h11, 8'h33, 8'hB3, 8'h33, 8'h03};
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    always #4 clk = ~clk;
    clock_config dut_u (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_PRIMARY_CLOCK_INPUT(pri), .I_SECONDARY_CLOCK_INPUT(sec), .I_HOST_BUS_CLOCK(hbc),
        .I_CONFIG_STRAP_PINS(straps), .I_MEM_REQ(req), .O_MEM_GRANT(grant), .O_MEMORY_CLOCK(mclk),
        .O_PANEL_PIXEL_CLOCK(pclk), .O_MONITOR_TV_PIXEL_CLOCK(tclk), .O_MEDIA_PORT_CLOCK(dclk),
        .O_INTERNAL_BUS_CLOCK(bclk), .O_CONFIG_STRAP_STATUS(status));
    // sources at periods 8, 16 and 12 cycles, slow enough to be sampled; also the hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pri <= cyc[2];
        sec <= cyc[3];
        hbc <= (cyc % 12) < 6;
        if (cyc > 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    // pulse counts may slip by one with the divider phase
    task near(input string name, input int seen, input int exp);
        check(name, 32'(((seen - exp) inside {-1, 0, 1}) ? exp : seen), 32'(exp));
    endtask : near
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no assumed wait count: only the cycle ceiling ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task do_reset(input logic [15:0] s);
        @(posedge clk);
        rst_n <= 1'b0;
        straps <= s;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        straps <= ~s;
    endtask : do_reset
    // program all four clocks and count pulses over 384 cycles
    task measure(input logic [7:0] m, p, t, d, input int bdiv);
        int r [4];
        int c [5];
        apb(1'b1, 8'h40, {24'h0, m});
        apb(1'b1, 8'h50, {24'h0, p});
        apb(1'b1, 8'h60, {24'h0, t});
        apb(1'b1, 8'h70, {24'h0, d});
        c = '{default: 0};
        r = '{48, 32, 24, (m[0] ? 32 : 48) / (m[4] ? 2 : 1)};
        repeat (16) @(posedge clk);
        repeat (384) begin
            @(posedge clk);
            c[0] += mclk;
            c[1] += pclk;
            c[2] += tclk;
            c[3] += dclk;
            c[4] += bclk;
        end
        near("memory clock", c[0], r[3]);
        near("panel clock", c[1], r[p[1:0]] / (int'(p[5:4]) + 1));
        near("monitor clock", c[2], r[t[1:0]] * (t[7] ? 2 : 1) / (int'(t[5:4]) + 1));
        near("media clock", c[3], r[d[1:0]] / (int'(d[5:4]) + 1));
        near("bus clock", c[4], 32 / bdiv);
    endtask : measure
    task handshake(input logic [1:0] code);
        int lat;
        int ticks;
        apb(1'b1, 8'h78, {30'h0, code});
        @(posedge clk);
        req <= 1'b1;
        lat = 0;
        ticks = 0;
        do begin
            @(posedge clk);
            lat++;
            ticks += mclk;
        end while (grant !== 1'b1 && lat < 100);
        req <= 1'b0;
        check("grant seen", {31'h0, grant}, 32'h1);
        if (code == 2'h0) check("grant latency", 32'(lat), 32'd2);
        else near("wait ticks", ticks, (code == 2'h3) ? 2 : int'(code));
    endtask : handshake
    initial begin
        do_reset(16'h1234);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check("reset value", rd, 32'h0);
            // divide bit first, so the all-ones write never moves the memory source at full rate
            apb(1'b1, ra[i], 32'h10);
            apb(1'b1, ra[i], 32'hFFFFFFFF);
            apb(1'b0, ra[i], 32'h0);
            check("masked readback", rd, {24'h0, rm[i]});
            check("mapped error", {31'h0, err}, 32'h0);
        end
        apb(1'b1, 8'h44, 32'hFFFFFFFF);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h44, 32'h0);
        check("unmapped read", rd, 32'h0);
        check("strap status", {16'h0, status}, 32'h1234);
        measure(8'h00, 8'h00, 8'h11, 8'h32, 2);
        measure(8'h10, 8'h23, 8'h80, 8'h03, 2);
        measure(8'h11, 8'h31, 8'hA2, 8'h21, 2);
        measure(8'h01, 8'h13, 8'h33, 8'h10, 2);
        do_reset(16'h0FED);
        check("strap status", {16'h0, status}, 32'h0FED);
        measure(8'h00, 8'h02, 8'h01, 8'h00, 1);
        // halved primary memory clock against the unhalved bus clock meets codes 1 and 2; code 3 is reserved
        apb(1'b1, 8'h40, 32'h10);
        for (int k = 0; k < 4; k++) handshake(2'(k % 3));
        tally_and_finish();
    end
endmodule : clock_config_tb
